// file: verilog/timer16_regs.vh
// Register map and constants of the 16-bit compare timer
`ifndef TIMER16_REGS_VH
`define TIMER16_REGS_VH
`define T16_OFF_CTRL      12'h000
`define T16_OFF_COUNT     12'h004
`define T16_OFF_CMPA      12'h008
`define T16_OFF_CMPB      12'h00c
`define T16_OFF_CAPTOP    12'h010
`define T16_OFF_FLAGS     12'h014
`define T16_OFF_PINDIR    12'h018
`define T16_CTRL_WGM_LSB  0
`define T16_CTRL_CS_LSB   4
`define T16_CTRL_COMA_LSB 8
`define T16_CTRL_COMB_LSB 10
`define T16_FLAG_TOV      0
`define T16_FLAG_CMPA     1
`define T16_FLAG_CMPB     2
`define T16_FLAG_CAP      3
`define T16_RST_CTRL      32'h00000000
`define T16_RST_WORD16    16'h0000
`define T16_MODE_CTC_A    4'h4
`define T16_MODE_FP8      4'h5
`define T16_MODE_FP9      4'h6
`define T16_MODE_FP10     4'h7
`define T16_MODE_CTC_CAP  4'hc
`define T16_MODE_FP_CAP   4'he
`define T16_MODE_FP_A     4'hf
`define T16_TOP8          16'h00ff
`define T16_TOP9          16'h01ff
`define T16_TOP10         16'h03ff
`define T16_MAX           16'hffff
`define T16_COM_NONE      2'h0
`define T16_COM_TOGGLE    2'h1
`define T16_COM_NONINV    2'h2
`define T16_COM_INV       2'h3
`define T16_RESP_OKAY     2'h0
`define T16_RESP_SLVERR   2'h2
`endif

// file: verilog/prescale_tick.v
// Clock prescaler that issues one-cycle timer ticks
`timescale 1ns/1ps
`default_nettype none
module prescale_tick (
  input  wire       core_clk,
  input  wire       rst,
  input  wire [2:0] clk_select,
  output reg        tick
);
  reg [9:0] div_q;
  always @(posedge core_clk) begin
    if (rst) begin
      div_q <= 10'h000;
    end else begin
      div_q <= div_q + 10'h001;
    end
  end
  // Select 0 stops, 1..5 give 1, 8, 64, 256, 1024
  always @* begin
    case (clk_select)
      3'h1: tick = 1'b1;
      3'h2: tick = (div_q[2:0] == 3'h7);
      3'h3: tick = (div_q[5:0] == 6'h3f);
      3'h4: tick = (div_q[7:0] == 8'hff);
      3'h5: tick = (div_q == 10'h3ff);
      default: tick = 1'b0;
    endcase
  end
endmodule // prescale_tick
`default_nettype wire

// file: verilog/wave_channel.v
// One compare channel: output action state
`timescale 1ns/1ps
`default_nettype none
`include "timer16_regs.vh"
module wave_channel (
  input  wire       core_clk,
  input  wire       rst,
  input  wire       tick,
  input  wire       fast_pwm,
  input  wire       match,
  input  wire       at_top,
  input  wire [1:0] action,
  input  wire       pin_dir,
  output reg        wave_q,
  output wire       pin_out,
  output wire       pin_oe_n
);
  always @(posedge core_clk) begin
    if (rst) begin
      wave_q <= 1'b0;
    end else if (tick) begin
      case (action)
        `T16_COM_TOGGLE: begin
          if (match) begin
            wave_q <= ~wave_q;
          end
        end
        `T16_COM_NONINV: begin
          if (fast_pwm && match) begin
            wave_q <= 1'b0;
          end else if (fast_pwm && at_top) begin
            wave_q <= 1'b1;
          end else if (!fast_pwm && match) begin
            wave_q <= 1'b0;
          end
        end
        `T16_COM_INV: begin
          if (fast_pwm && match) begin
            wave_q <= 1'b1;
          end else if (fast_pwm && at_top) begin
            wave_q <= 1'b0;
          end else if (!fast_pwm && match) begin
            wave_q <= 1'b1;
          end
        end
        default: wave_q <= wave_q;
      endcase
    end
  end
  assign pin_out  = wave_q;
  assign pin_oe_n = ~pin_dir;
endmodule // wave_channel
`default_nettype wire

// file: verilog/timer16_pwm.v
// 16-bit timer with clear-on-match and fast PWM, AXI4-Lite registers
//
// The AXI4-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "timer16_regs.vh"
module timer16_pwm (
  input  wire        core_clk,
  input  wire        rst,
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output wire        wave_out_a,
  output wire        wave_out_a_oe_n,
  output wire        wave_out_b,
  output wire        wave_out_b_oe_n
);
  reg  [31:0] ctrl_q;
  reg  [15:0] timer_count_value_q;
  reg  [15:0] compare_value_a_q;
  reg  [15:0] compare_buf_a_q;
  reg  [15:0] compare_value_b_q;
  reg  [15:0] compare_buf_b_q;
  reg  [15:0] capture_top_value_q;
  reg  [3:0]  flags_q;
  reg  [1:0]  pin_dir_q;
  reg         block_q;
  reg  [11:0] awaddr_q;
  reg         aw_held_q;
  reg  [31:0] wdata_q;
  reg  [3:0]  wstrb_q;
  reg         w_held_q;
  wire        tick;
  wire [3:0]  waveform_mode_select;
  wire [1:0]  output_action_a;
  wire [1:0]  output_action_b;
  wire        ctc_mode;
  wire        fast_pwm;
  wire        fixed_top;
  reg  [15:0] top_value;
  reg  [15:0] fixed_mask;
  wire        at_top;
  wire        match_a;
  wire        match_b;
  wire        do_write;
  wire [31:0] wr_word;
  wire        wr_ctrl;
  wire        wr_count;
  wire        wr_cmpa;
  wire        wr_cmpb;
  wire        wr_cap;
  wire        wr_flags;
  wire        wr_dir;
  wire        wr_known;
  wire [15:0] cmp_wr_value;
  wire [3:0]  flag_set;

  // Merge byte lanes into an existing word
  function [31:0] lane_merge;
    input [31:0] old_word;
    input [31:0] new_word;
    input [3:0]  strb;
    integer      i;
    begin
      lane_merge = old_word;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          lane_merge[i*8 +: 8] = new_word[i*8 +: 8];
        end
      end
    end
  endfunction

  // Match an address against one register offset
  function addr_hit;
    input [11:0] addr;
    input [11:0] offset;
    begin
      addr_hit = (addr[11:2] == offset[11:2]);
    end
  endfunction

  assign waveform_mode_select = ctrl_q[`T16_CTRL_WGM_LSB +: 4];
  assign output_action_a      = ctrl_q[`T16_CTRL_COMA_LSB +: 2];
  assign output_action_b      = ctrl_q[`T16_CTRL_COMB_LSB +: 2];
  assign ctc_mode = (waveform_mode_select == `T16_MODE_CTC_A) ||
                    (waveform_mode_select == `T16_MODE_CTC_CAP);
  assign fast_pwm = (waveform_mode_select == `T16_MODE_FP8) ||
                    (waveform_mode_select == `T16_MODE_FP9) ||
                    (waveform_mode_select == `T16_MODE_FP10) ||
                    (waveform_mode_select == `T16_MODE_FP_CAP) ||
                    (waveform_mode_select == `T16_MODE_FP_A);
  assign fixed_top = (waveform_mode_select == `T16_MODE_FP8) ||
                     (waveform_mode_select == `T16_MODE_FP9) ||
                     (waveform_mode_select == `T16_MODE_FP10);

  always @* begin
    case (waveform_mode_select)
      `T16_MODE_CTC_A:   top_value = compare_value_a_q;
      `T16_MODE_CTC_CAP: top_value = capture_top_value_q;
      `T16_MODE_FP8:     top_value = `T16_TOP8;
      `T16_MODE_FP9:     top_value = `T16_TOP9;
      `T16_MODE_FP10:    top_value = `T16_TOP10;
      `T16_MODE_FP_CAP:  top_value = capture_top_value_q;
      `T16_MODE_FP_A:    top_value = compare_value_a_q;
      default:           top_value = `T16_MAX;
    endcase
  end

  always @* begin
    case (waveform_mode_select)
      `T16_MODE_FP8:  fixed_mask = `T16_TOP8;
      `T16_MODE_FP9:  fixed_mask = `T16_TOP9;
      `T16_MODE_FP10: fixed_mask = `T16_TOP10;
      default:        fixed_mask = `T16_MAX;
    endcase
  end

  // Exact equality only: a TOP below the count is missed and the count wraps
  assign at_top  = (timer_count_value_q == top_value) && !block_q;
  assign match_a = (timer_count_value_q == compare_value_a_q) && !block_q;
  assign match_b = (timer_count_value_q == compare_value_b_q) && !block_q;

  prescale_tick u_prescale (
    .core_clk   (core_clk),
    .rst        (rst),
    .clk_select (ctrl_q[`T16_CTRL_CS_LSB +: 3]),
    .tick       (tick)
  );

  // AXI4-Lite write path: address and data held until both present
  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
  assign do_write      = aw_held_q && w_held_q && !s_axi_bvalid;
  assign wr_ctrl  = do_write && addr_hit(awaddr_q, `T16_OFF_CTRL);
  assign wr_count = do_write && addr_hit(awaddr_q, `T16_OFF_COUNT);
  assign wr_cmpa  = do_write && addr_hit(awaddr_q, `T16_OFF_CMPA);
  assign wr_cmpb  = do_write && addr_hit(awaddr_q, `T16_OFF_CMPB);
  assign wr_cap   = do_write && addr_hit(awaddr_q, `T16_OFF_CAPTOP);
  assign wr_flags = do_write && addr_hit(awaddr_q, `T16_OFF_FLAGS);
  assign wr_dir   = do_write && addr_hit(awaddr_q, `T16_OFF_PINDIR);
  assign wr_known = wr_ctrl || wr_count || wr_cmpa || wr_cmpb ||
                    wr_cap || wr_flags || wr_dir;
  assign wr_word  = lane_merge(32'h00000000, wdata_q, wstrb_q);
  assign cmp_wr_value = wr_word[15:0] & fixed_mask;

  always @(posedge core_clk) begin
    if (rst) begin
      aw_held_q    <= 1'b0;
      w_held_q     <= 1'b0;
      awaddr_q     <= 12'h000;
      wdata_q      <= 32'h00000000;
      wstrb_q      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `T16_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_q    <= 1'b0;
        w_held_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? `T16_RESP_OKAY : `T16_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register writes, counter and compare buffering
  always @(posedge core_clk) begin
    if (rst) begin
      ctrl_q              <= `T16_RST_CTRL;
      timer_count_value_q <= `T16_RST_WORD16;
      compare_value_a_q   <= `T16_RST_WORD16;
      compare_buf_a_q     <= `T16_RST_WORD16;
      compare_value_b_q   <= `T16_RST_WORD16;
      compare_buf_b_q     <= `T16_RST_WORD16;
      capture_top_value_q <= `T16_RST_WORD16;
      pin_dir_q           <= 2'h0;
      block_q             <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= {20'h00000, wr_word[11:0]};
      end
      if (wr_dir) begin
        pin_dir_q <= wr_word[1:0];
      end
      if (wr_cap) begin
        capture_top_value_q <= wr_word[15:0];
      end
      if (wr_count) begin
        block_q <= 1'b1;
      end else if (tick) begin
        block_q <= 1'b0;
      end
      if (wr_count) begin
        timer_count_value_q <= wr_word[15:0];
      end else if (tick) begin
        if ((ctc_mode || fast_pwm) && at_top) begin
          timer_count_value_q <= `T16_RST_WORD16;
        end else begin
          timer_count_value_q <= timer_count_value_q + 16'h0001;
        end
      end
      if (wr_cmpa) begin
        compare_buf_a_q <= cmp_wr_value;
        if (!fast_pwm) begin
          compare_value_a_q <= cmp_wr_value;
        end
      end else if (fast_pwm && tick && at_top) begin
        compare_value_a_q <= compare_buf_a_q;
      end
      if (wr_cmpb) begin
        compare_buf_b_q <= cmp_wr_value;
        if (!fast_pwm) begin
          compare_value_b_q <= cmp_wr_value;
        end
      end else if (fast_pwm && tick && at_top) begin
        compare_value_b_q <= compare_buf_b_q;
      end
    end
  end

  // Flag sources; set wins over a software clear in the same cycle
  assign flag_set[`T16_FLAG_TOV] = tick && (
      (fast_pwm && at_top) ||
      (!fast_pwm && timer_count_value_q == `T16_MAX));
  assign flag_set[`T16_FLAG_CMPA] = tick && (match_a ||
      (waveform_mode_select == `T16_MODE_FP_A && at_top));
  assign flag_set[`T16_FLAG_CMPB] = tick && match_b;
  assign flag_set[`T16_FLAG_CAP]  = tick && at_top &&
      ((waveform_mode_select == `T16_MODE_CTC_CAP) ||
       (waveform_mode_select == `T16_MODE_FP_CAP));

  always @(posedge core_clk) begin
    if (rst) begin
      flags_q <= 4'h0;
    end else begin
      flags_q <= (flags_q & ~(wr_flags ? wr_word[3:0] : 4'h0)) | flag_set;
    end
  end

  // AXI4-Lite read path
  assign s_axi_arready = !s_axi_rvalid;
  always @(posedge core_clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `T16_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `T16_RESP_OKAY;
      if (addr_hit(s_axi_araddr, `T16_OFF_CTRL)) begin
        s_axi_rdata <= ctrl_q;
      end else if (addr_hit(s_axi_araddr, `T16_OFF_COUNT)) begin
        s_axi_rdata <= {16'h0000, timer_count_value_q};
      end else if (addr_hit(s_axi_araddr, `T16_OFF_CMPA)) begin
        s_axi_rdata <= {16'h0000, compare_buf_a_q};
      end else if (addr_hit(s_axi_araddr, `T16_OFF_CMPB)) begin
        s_axi_rdata <= {16'h0000, compare_buf_b_q};
      end else if (addr_hit(s_axi_araddr, `T16_OFF_CAPTOP)) begin
        s_axi_rdata <= {16'h0000, capture_top_value_q};
      end else if (addr_hit(s_axi_araddr, `T16_OFF_FLAGS)) begin
        s_axi_rdata <= {28'h0000000, flags_q};
      end else if (addr_hit(s_axi_araddr, `T16_OFF_PINDIR)) begin
        s_axi_rdata <= {30'h00000000, pin_dir_q};
      end else begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `T16_RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  wave_channel u_chan_a (
    .core_clk (core_clk),
    .rst      (rst),
    .tick     (tick),
    .fast_pwm (fast_pwm),
    .match    (match_a),
    .at_top   (at_top),
    .action   (output_action_a),
    .pin_dir  (pin_dir_q[0]),
    .wave_q   (),
    .pin_out  (wave_out_a),
    .pin_oe_n (wave_out_a_oe_n)
  );

  wave_channel u_chan_b (
    .core_clk (core_clk),
    .rst      (rst),
    .tick     (tick),
    .fast_pwm (fast_pwm),
    .match    (match_b),
    .at_top   (at_top),
    .action   (((output_action_b == `T16_COM_TOGGLE) && fast_pwm) ?
               `T16_COM_NONE : output_action_b),
    .pin_dir  (pin_dir_q[1]),
    .wave_q   (),
    .pin_out  (wave_out_b),
    .pin_oe_n (wave_out_b_oe_n)
  );
endmodule // timer16_pwm
`default_nettype wire

// file: sim/pin_load.sv
// Port pin with weak pull-up, seen by the outside circuitry
`timescale 1ns/1ps
`default_nettype none
module pin_load (
  input  wire logic wave,
  input  wire logic oe_n,
  output wire logic pin
);
  assign pin = oe_n ? 1'b1 : wave;
endmodule // pin_load
`default_nettype wire

// file: sim/timer16_pwm_sva.sv
// Bus and pin checks for the compare timer
`timescale 1ns/1ps
`default_nettype none
module timer16_pwm_sva (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        wave_out_a,
  input wire logic        wave_out_a_oe_n,
  input wire logic        wave_out_b,
  input wire logic        wave_out_b_oe_n
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  a_pins_after_reset: assert property ($fell(rst) |-> !wave_out_a && !wave_out_b
    && wave_out_a_oe_n && wave_out_b_oe_n) else $error("pins not idle after reset");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped early");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data dropped early");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("no write response");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("no read data");
  a_resp_codes: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2)
    else $error("bad write response code");
  a_dir_by_write: assert property (!$stable(wave_out_a_oe_n) && !$past(rst)
    |-> s_axi_bvalid) else $error("pin enable moved without a write");
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  c_wave_driven: cover property (!wave_out_a_oe_n && $rose(wave_out_a));
  c_read_done: cover property (s_axi_rvalid && s_axi_rready);
endmodule // timer16_pwm_sva
bind timer16_pwm timer16_pwm_sva u_sva (.core_clk(core_clk), .rst(rst),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .wave_out_a(wave_out_a), .wave_out_a_oe_n(wave_out_a_oe_n),
  .wave_out_b(wave_out_b), .wave_out_b_oe_n(wave_out_b_oe_n));
`default_nettype wire

// file: sim/tb_top.sv
// Self-checking bench for the compare timer
`timescale 1ns/1ps
`default_nettype none
`include "timer16_regs.vh"
module tb_top;
  logic        core_clk = 1'b0;
  logic        rst      = 1'b1;
  logic [11:0] awaddr   = 12'h000;
  logic [11:0] araddr   = 12'h000;
  logic [31:0] wdata    = 32'h0;
  logic        awvalid  = 1'b0;
  logic        wvalid   = 1'b0;
  logic        bready   = 1'b0;
  logic        arvalid  = 1'b0;
  logic        rready   = 1'b0;
  wire         awready, wready, bvalid, arready, rvalid, wa, wa_n, wb, wb_n, pin_a, pin_b;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  logic [31:0] rd;
  logic [1:0]  resp;
  logic        p;
  int          error_cnt = 0;
  int          compares  = 0;
  int          len;
  int          divs[6] = '{0, 1, 8, 64, 256, 1024};

  initial forever #2 core_clk = ~core_clk;

  timer16_pwm u_dut (.core_clk(core_clk), .rst(rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .wave_out_a(wa),
    .wave_out_a_oe_n(wa_n), .wave_out_b(wb), .wave_out_b_oe_n(wb_n));
  pin_load u_pa (.wave(wa), .oe_n(wa_n), .pin(pin_a));
  pin_load u_pb (.wave(wb), .oe_n(wb_n), .pin(pin_b));

  task automatic tally_and_finish;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic bail;
    error_cnt++;
    $display("MISMATCH t=%0t wait timed out", $time);
    tally_and_finish();
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic aw_ok, w_ok, b_ok;
    int n;
    b_ok = 1'b0;
    n = 0;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_ok) begin
      @(negedge core_clk);
      aw_ok = awvalid && awready;
      w_ok = wvalid && wready;
      b_ok = bvalid;
      @(posedge core_clk);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
      n++;
      if (n > 100) bail();
    end
    bready <= 1'b0;
  endtask

  task automatic rdr(input logic [11:0] a);
    logic ar_ok, r_ok;
    int n;
    r_ok = 1'b0;
    n = 0;
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_ok) begin
      @(negedge core_clk);
      ar_ok = arvalid && arready;
      r_ok = rvalid;
      rd = rdata;
      resp = rresp;
      @(posedge core_clk);
      if (ar_ok) arvalid <= 1'b0;
      n++;
      if (n > 100) bail();
    end
    rready <= 1'b0;
  endtask

  // Length of one whole run of level v on a pin
  task automatic run_len(input logic ch, input logic v);
    int n;
    len = 0;
    for (n = 0; n < 8000 && (ch ? pin_b : pin_a) === v; n++) @(negedge core_clk);
    for (; n < 8000 && (ch ? pin_b : pin_a) !== v; n++) @(negedge core_clk);
    for (; n < 8000 && (ch ? pin_b : pin_a) === v; n++) begin
      @(negedge core_clk);
      len++;
    end
    if (n >= 8000) bail();
  endtask

  function automatic logic [31:0] ctl(input logic [3:0] m, input logic [2:0] cs,
                                      input logic [1:0] a, input logic [1:0] b);
    ctl = {20'h0, b, a, 1'b0, cs, m};
  endfunction

  task automatic t_reset;
    rdr(`T16_OFF_COUNT);
    chk(rd, 32'h0);
    rdr(`T16_OFF_FLAGS);
    chk(rd, 32'h0);
    chk({31'h0, pin_a}, 32'h1);
    rdr(12'h100);
    chk({30'h0, resp}, {30'h0, `T16_RESP_SLVERR});
  endtask

  task automatic t_ctc_wrap;
    wr(`T16_OFF_CAPTOP, 32'h5);
    wr(`T16_OFF_CTRL, ctl(`T16_MODE_CTC_CAP, 3'h0, 2'h0, 2'h0));
    wr(`T16_OFF_COUNT, 32'hfff0);
    wr(`T16_OFF_FLAGS, 32'hf);
    wr(`T16_OFF_CTRL, ctl(`T16_MODE_CTC_CAP, 3'h1, 2'h0, 2'h0));
    rdr(`T16_OFF_FLAGS);
    chk(rd & 32'h9, 32'h0);
    repeat (40) @(posedge core_clk);
    rdr(`T16_OFF_FLAGS);
    chk(rd & 32'h9, 32'h9);
    rdr(`T16_OFF_COUNT);
    chk({31'h0, rd <= 32'h5}, 32'h1);
  endtask

  task automatic t_ctc_toggle;
    wr(`T16_OFF_CMPA, 32'h9);
    wr(`T16_OFF_CTRL, ctl(`T16_MODE_CTC_A, 3'h1, `T16_COM_TOGGLE, 2'h0));
    wr(`T16_OFF_PINDIR, 32'h1);
    chk({31'h0, wa_n}, 32'h0);
    run_len(1'b0, 1'b1);
    chk(len, 10);
    wr(`T16_OFF_FLAGS, 32'hf);
    repeat (12) @(posedge core_clk);
    rdr(`T16_OFF_FLAGS);
    chk(rd & 32'hb, 32'h2);
    // Stop and rewind so the smaller TOP is not missed
    wr(`T16_OFF_CTRL, ctl(`T16_MODE_CTC_A, 3'h0, `T16_COM_TOGGLE, 2'h0));
    wr(`T16_OFF_COUNT, 32'h0);
    wr(`T16_OFF_CMPA, 32'h1);
    for (int cs = 1; cs < 6; cs++) begin
      wr(`T16_OFF_CTRL, ctl(`T16_MODE_CTC_A, cs[2:0], `T16_COM_TOGGLE, 2'h0));
      run_len(1'b0, 1'b1);
      chk(len, 2 * divs[cs]);
    end
    wr(`T16_OFF_CTRL, ctl(`T16_MODE_CTC_A, 3'h1, `T16_COM_NONE, 2'h0));
    p = pin_a;
    repeat (20) begin
      @(negedge core_clk);
      chk({31'h0, pin_a}, {31'h0, p});
    end
    // Counter write while stopped masks the first match
    wr(`T16_OFF_CTRL, ctl(`T16_MODE_CTC_A, 3'h0, `T16_COM_NONE, 2'h0));
    wr(`T16_OFF_CMPA, 32'h9);
    wr(`T16_OFF_CMPB, 32'h4);
    wr(`T16_OFF_COUNT, 32'h4);
    wr(`T16_OFF_FLAGS, 32'hf);
    wr(`T16_OFF_CTRL, ctl(`T16_MODE_CTC_A, 3'h1, `T16_COM_NONE, 2'h0));
    rdr(`T16_OFF_FLAGS);
    chk(rd & 32'h4, 32'h0);
    repeat (12) @(posedge core_clk);
    rdr(`T16_OFF_FLAGS);
    chk(rd & 32'h4, 32'h4);
  endtask

  task automatic t_fast_fixed;
    wr(`T16_OFF_CTRL, ctl(`T16_MODE_FP8, 3'h1, `T16_COM_NONINV, `T16_COM_NONINV));
    wr(`T16_OFF_PINDIR, 32'h3);
    wr(`T16_OFF_CMPA, 32'h1234);
    rdr(`T16_OFF_CMPA);
    chk(rd, 32'h34);
    wr(`T16_OFF_CMPA, 32'h40);
    wr(`T16_OFF_CMPB, 32'h80);
    run_len(1'b0, 1'b1);
    chk(len, 32'h41);
    run_len(1'b0, 1'b0);
    chk(len, 32'h100 - 32'h41);
    run_len(1'b1, 1'b1);
    chk(len, 32'h81);
    wr(`T16_OFF_FLAGS, 32'hf);
    repeat (300) @(posedge core_clk);
    rdr(`T16_OFF_FLAGS);
    chk(rd & 32'h7, 32'h7);
    wr(`T16_OFF_CTRL, ctl(`T16_MODE_FP8, 3'h1, `T16_COM_INV, `T16_COM_NONINV));
    run_len(1'b0, 1'b0);
    chk(len, 32'h41);
    wr(`T16_OFF_CTRL, ctl(`T16_MODE_FP9, 3'h1, `T16_COM_NONINV, `T16_COM_NONINV));
    wr(`T16_OFF_CMPA, 32'hffff);
    rdr(`T16_OFF_CMPA);
    chk(rd, {16'h0, `T16_TOP9});
    wr(`T16_OFF_CTRL, ctl(`T16_MODE_FP10, 3'h1, `T16_COM_NONINV, `T16_COM_NONINV));
    wr(`T16_OFF_CMPA, 32'hffff);
    rdr(`T16_OFF_CMPA);
    chk(rd, {16'h0, `T16_TOP10});
  endtask

  task automatic t_fast_top;
    wr(`T16_OFF_CAPTOP, 32'h9);
    wr(`T16_OFF_CMPA, 32'h0);
    wr(`T16_OFF_CTRL, ctl(`T16_MODE_FP_CAP, 3'h1, `T16_COM_NONINV, 2'h0));
    wr(`T16_OFF_COUNT, 32'h0);
    run_len(1'b0, 1'b1);
    chk(len, 1);
    run_len(1'b0, 1'b0);
    chk(len, 9);
    wr(`T16_OFF_FLAGS, 32'hf);
    repeat (12) @(posedge core_clk);
    rdr(`T16_OFF_FLAGS);
    chk(rd & 32'hb, 32'hb);
    wr(`T16_OFF_CMPA, 32'h9);
    repeat (30) @(negedge core_clk);
    p = pin_a;
    repeat (30) begin
      @(negedge core_clk);
      chk({31'h0, pin_a}, {31'h0, p});
    end
    wr(`T16_OFF_CTRL, ctl(`T16_MODE_FP_A, 3'h1, `T16_COM_TOGGLE, 2'h0));
    wr(`T16_OFF_CMPA, 32'h7);
    run_len(1'b0, 1'b1);
    chk(len, 8);
  endtask

  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_ctc_wrap();
    t_ctc_toggle();
    t_fast_fixed();
    t_fast_top();
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
